// *** hdl/ivt_trap_entry.sv ***
// Purpose: maps request nodes and hardware traps onto vector addresses
// Assumes: node requests arrive indexed by trap number minus 0x10
// Notes: core acknowledges a presented vector with vector_ack
`timescale 1ns/100ps
// Function
// RL1 - vectors are placed in the segment chosen by software
// RL2 - slot spacing comes from a configuration field, default four bytes
// RL3 - each node has one fixed trap number and slot
// RL4 - second serial channel nodes and listed free nodes have no peripheral source; on acceptance the code reloads their flag from unmasked periph_req
// RL5 - a run-time error takes a trap at once, with no mask
// RL6 - each hardware trap sets its own trap flag bit
// RL7 - traps preempt anything except a higher priority trap service; the code also holds a trap back during a service of the same trap flag bit
// RL8 - node requests never preempt a trap service
// RL9 - each node has request flag, enable flag and priority
// RL10 - sixteen levels; only strictly higher priority preempts
// RL11 - software may set a free node's request flag to raise it
// RL12 - trap flags stay set until software clears them
// RL13 - vector is segment base plus trap number times spacing
module ivt_trap_entry (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic has_ser1,
    input wire logic [7:0] vector_segment_select,
    input wire logic [1:0] vector_spacing_field,
    input wire logic [79:0] periph_req,
    input wire logic [79:0] node_enable,
    input wire logic [319:0] node_prio,
    input wire logic [79:0] sw_req_set,
    input wire logic [79:0] req_clr,
    input wire logic [7:0] hw_trap_evt,
    input wire logic [7:0] trap_flag_clr,
    input wire logic vector_ack,
    input wire logic service_done,
    output logic [79:0] node_request_flag,
    output logic [7:0] trap_flag_register,
    output logic vector_valid,
    output logic [23:0] vector_addr,
    output logic [6:0] vector_trap,
    output logic in_trap_service,
    output logic [3:0] cur_prio
);
    // two-flop release so every register leaves reset on the same edge
    logic rst_s1_q, rst_s2_q;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // each spacing step doubles the slot distance; zero keeps two-word slots
    function automatic logic [23:0] vec_of(input logic [7:0] seg, input logic [1:0] sc,
                                           input logic [6:0] tn);
        logic [15:0] off;
        off = 16'h0000;
        off = {7'h00, tn, 2'h0} << sc; // RL2
        vec_of = {seg, off}; // RL1 RL13
    endfunction : vec_of

    // nodes with no peripheral behind them; second serial channel joins them when absent
    function automatic logic node_free(input logic [6:0] tn, input logic ser1);
        node_free = (tn == ivt_pkg::UNASG_0) || (tn == ivt_pkg::UNASG_1) ||
                    (tn == ivt_pkg::UNASG_2) || (tn == ivt_pkg::UNASG_3) ||
                    (tn == ivt_pkg::UNASG_4) ||
                    (!ser1 && ((tn == ivt_pkg::SER1_TX) || (tn == ivt_pkg::SER1_RX) ||
                               (tn == ivt_pkg::SER1_ERR) || (tn == ivt_pkg::SER1_AB) ||
                               (tn == ivt_pkg::SER1_TB)));
    endfunction : node_free

    function automatic logic [6:0] trap_num(input int b);
        case (b)
            0: trap_num = ivt_pkg::TRAP_NMI;
            1: trap_num = ivt_pkg::TRAP_STKOF;
            2: trap_num = ivt_pkg::TRAP_STKUF;
            3: trap_num = ivt_pkg::TRAP_SBRK;
            default: trap_num = ivt_pkg::TRAP_CLASSB;
        endcase
    endfunction : trap_num

    ivt_pkg::ivt_state_t state_q, state_d;
    logic [79:0] req_q, req_d;
    logic [7:0] tfr_q, tfr_d;
    logic [7:0] tpend_q, tpend_d;
    logic vv_q, vv_d;
    logic [23:0] va_q, va_d;
    logic [6:0] vt_q, vt_d;
    logic [3:0] prio_q, prio_d;
    logic [2:0] tlvl_q, tlvl_d;
    logic busy_q, busy_d;

    always_comb begin
        logic found;
        logic [3:0] bp;
        logic [6:0] bi;
        logic tfound;
        logic [2:0] tb;
        logic [6:0] tn;
        found = 1'b0;
        bp = 4'h0;
        bi = 7'h00;
        tfound = 1'b0;
        tb = 3'h0;
        tn = 7'h00;
        state_d = state_q;
        tfr_d = tfr_q;
        tpend_d = tpend_q;
        vv_d = vv_q;
        va_d = va_q;
        vt_d = vt_q;
        prio_d = prio_q;
        tlvl_d = tlvl_q;
        busy_d = busy_q;
        for (int i = 0; i < ivt_pkg::NODE_CNT; i++) begin
            tn = ivt_pkg::NODE_BASE + 7'(i); // RL3
            // set wins over clear; free nodes only take software requests here, but acceptance reloads the flag from an unmasked periph_req
            req_d[i] = (req_q[i] && !req_clr[i]) || sw_req_set[i] || // RL9 RL11
                       (periph_req[i] && !node_free(tn, has_ser1)); // RL4
        end
        for (int b = 0; b < ivt_pkg::HWT_CNT; b++) begin
            tfr_d[b] = (tfr_q[b] && !trap_flag_clr[b]) || hw_trap_evt[b]; // RL6 RL12
            tpend_d[b] = tpend_q[b] || hw_trap_evt[b]; // RL5
        end
        // lower bit index means higher trap priority
        for (int b = ivt_pkg::HWT_CNT - 1; b >= 0; b--) begin
            if (tpend_q[b]) begin
                tfound = 1'b1;
                tb = 3'(b);
            end
        end
        for (int i = 0; i < ivt_pkg::NODE_CNT; i++) begin
            if (req_q[i] && node_enable[i] && node_prio[4*i +: 4] > bp) begin // RL10
                found = 1'b1;
                bp = node_prio[4*i +: 4];
                bi = 7'(i);
            end
        end
        // service_done ends whatever service is current, trap or node
        if (service_done) begin
            busy_d = 1'b0;
            prio_d = 4'h0;
        end
        unique case (state_q)
            ivt_pkg::IVT_IDLE: begin
                // a pending trap is taken before any node, but a node vector already presented holds it back until vector_ack
                if (tfound && (!busy_q || tb < tlvl_q)) begin // RL7
                    state_d = ivt_pkg::IVT_TRAP;
                    vv_d = 1'b1;
                    vt_d = trap_num(int'(tb));
                    va_d = vec_of(vector_segment_select, vector_spacing_field,
                                  trap_num(int'(tb))); // RL5
                    tpend_d[tb] = hw_trap_evt[tb];
                    tlvl_d = tb;
                end else if (found && !busy_q && bp > prio_q) begin // RL8 RL10
                    state_d = ivt_pkg::IVT_NODE;
                    vv_d = 1'b1;
                    vt_d = ivt_pkg::NODE_BASE + 7'(bi);
                    va_d = vec_of(vector_segment_select, vector_spacing_field,
                                  ivt_pkg::NODE_BASE + 7'(bi));
                    // acceptance consumes the flag unless a fresh request lands now
                    req_d[bi] = sw_req_set[bi] || periph_req[bi];
                    prio_d = bp;
                end
            end
            ivt_pkg::IVT_NODE: begin
                if (vector_ack) begin
                    state_d = ivt_pkg::IVT_IDLE;
                    vv_d = 1'b0;
                end
            end
            ivt_pkg::IVT_TRAP: begin
                if (vector_ack) begin
                    state_d = ivt_pkg::IVT_IDLE;
                    vv_d = 1'b0;
                    // trap service stays marked until the core reports service_done
                    busy_d = 1'b1;
                end
            end
            default: begin
                state_d = ivt_pkg::IVT_IDLE;
                vv_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ivt_pkg::IVT_IDLE;
            req_q <= '0;
            tfr_q <= 8'h00;
            tpend_q <= 8'h00;
            vv_q <= 1'b0;
            va_q <= 24'h000000;
            vt_q <= 7'h00;
            prio_q <= 4'h0;
            tlvl_q <= 3'h7;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            tfr_q <= tfr_d;
            tpend_q <= tpend_d;
            vv_q <= vv_d;
            va_q <= va_d;
            vt_q <= vt_d;
            prio_q <= prio_d;
            tlvl_q <= tlvl_d;
            busy_q <= busy_d;
        end
    end

    // outputs are plain register copies, no logic after the flops
    assign node_request_flag = req_q;
    assign trap_flag_register = tfr_q;
    assign vector_valid = vv_q;
    assign vector_addr = va_q;
    assign vector_trap = vt_q;
    assign in_trap_service = busy_q;
    assign cur_prio = prio_q;
endmodule : ivt_trap_entry

// *** pkg/ivt_pkg.sv ***
// Purpose: constants for the interrupt vector and trap entry block
// Assumes: 16-bit core, 8-bit segment, trap numbers 0..127
// Notes: node slot numbers follow the fixed node map
package ivt_pkg;
    localparam int NODE_CNT = 80;
    localparam int HWT_CNT = 8;
    localparam logic [1:0] SPACING_RST = 2'h0;
    localparam logic [7:0] SEGMENT_RST = 8'h00;
    localparam logic [7:0] PRIO_HWT = 8'h00;
    // trap numbers of hardware traps, indexed by trap flag bit
    localparam logic [6:0] TRAP_NMI = 7'h02;
    localparam logic [6:0] TRAP_STKOF = 7'h04;
    localparam logic [6:0] TRAP_STKUF = 7'h06;
    localparam logic [6:0] TRAP_SBRK = 7'h08;
    localparam logic [6:0] TRAP_CLASSB = 7'h0a;
    localparam logic [6:0] NODE_BASE = 7'h10;
    localparam logic [6:0] NODE_TOP = 7'h5f;
    // unassigned nodes, kept free of peripheral sources
    localparam logic [6:0] UNASG_0 = 7'h40;
    localparam logic [6:0] UNASG_1 = 7'h41;
    localparam logic [6:0] UNASG_2 = 7'h4b;
    localparam logic [6:0] UNASG_3 = 7'h3f;
    localparam logic [6:0] UNASG_4 = 7'h58;
    // second serial channel nodes
    localparam logic [6:0] SER1_TX = 7'h48;
    localparam logic [6:0] SER1_RX = 7'h49;
    localparam logic [6:0] SER1_ERR = 7'h4a;
    localparam logic [6:0] SER1_AB = 7'h42;
    localparam logic [6:0] SER1_TB = 7'h5e;
    typedef enum logic [2:0] {
        IVT_IDLE = 3'h1,
        IVT_NODE = 3'h2,
        IVT_TRAP = 3'h4
    } ivt_state_t;
endpackage : ivt_pkg

// *** test/ivt_core_model.sv ***
// Purpose: core side that accepts presented vectors
// Assumes: ack is a one-cycle pulse
// Notes: lag sets how many cycles the core waits before acking
`timescale 1ns/100ps
module ivt_core_model (
    input wire logic sys_clk,
    input wire logic vector_valid,
    input wire logic [1:0] lag,
    output logic vector_ack
);
    logic [1:0] wait_q = 2'h0;
    initial vector_ack = 1'b0;
    always @(posedge sys_clk) begin
        if (vector_valid && !vector_ack && wait_q == lag) begin
            vector_ack <= 1'b1;
            wait_q <= 2'h0;
        end else begin
            vector_ack <= 1'b0;
            wait_q <= (vector_valid && !vector_ack) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule : ivt_core_model

// *** test/ivt_sva.sv ***
// Purpose: port checks for the vector and trap entry block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the top module below
`timescale 1ns/100ps
module ivt_sva (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] vector_segment_select,
    input wire logic [1:0] vector_spacing_field,
    input wire logic [79:0] sw_req_set,
    input wire logic [7:0] hw_trap_evt,
    input wire logic [7:0] trap_flag_clr,
    input wire logic vector_ack,
    input wire logic [79:0] node_request_flag,
    input wire logic [7:0] trap_flag_register,
    input wire logic vector_valid,
    input wire logic [23:0] vector_addr,
    input wire logic [6:0] vector_trap,
    input wire logic in_trap_service
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_idle_trap;
        hw_trap_evt[0] && !in_trap_service && !vector_valid;
    endsequence
    sequence s_trap_vec;
        ##[1:3] (vector_valid && vector_trap == 7'h02);
    endsequence
    a_trap_entry: assert property (s_idle_trap |-> s_trap_vec)
        else $error("trap vector not presented");
    a_flag_set: assert property (hw_trap_evt[0] |=> trap_flag_register[0])
        else $error("trap flag not set");
    a_flag_hold: assert property (trap_flag_register[0] && !trap_flag_clr[0]
        |=> trap_flag_register[0])
        else $error("trap flag lost");
    a_vec_segment: assert property (vector_valid
        |-> vector_addr[23:16] == vector_segment_select)
        else $error("vector segment wrong");
    a_vec_offset: assert property (vector_valid |-> vector_addr[15:0]
        == ((16'(vector_trap) << 2) << vector_spacing_field))
        else $error("vector offset wrong");
    a_vec_stands: assert property (vector_valid && !vector_ack
        |=> vector_valid && $stable(vector_addr))
        else $error("vector dropped before ack");
    a_ack_drop: assert property (vector_valid && vector_ack |=> !vector_valid)
        else $error("vector stays after ack");
    a_trap_guard: assert property (in_trap_service && vector_valid
        |-> vector_trap < 7'h10)
        else $error("node entered during trap service");
    a_free_node: assert property ($rose(node_request_flag[48])
        |-> $past(sw_req_set[48]))
        else $error("free node raised by hardware");
endmodule : ivt_sva

bind ivt_trap_entry ivt_sva u_sva (.sys_clk, .rst_b, .vector_segment_select,
    .vector_spacing_field, .sw_req_set, .hw_trap_evt, .trap_flag_clr, .vector_ack,
    .node_request_flag, .trap_flag_register, .vector_valid, .vector_addr,
    .vector_trap, .in_trap_service);

// *** test/tb.sv ***
// Purpose: self-checking bench for the vector and trap entry block
// Assumes: inputs change on the falling edge
// Notes: core model acks vectors, bench ends services
`timescale 1ns/100ps
module tb;
    logic sys_clk = 1'b0, rst_b = 1'b0, has_ser1 = 1'b1, service_done = 1'b0;
    logic [7:0] vector_segment_select = 8'h00, hw_trap_evt = 8'h00, trap_flag_clr = 8'h00;
    logic [1:0] vector_spacing_field = 2'h0, lag = 2'h0;
    logic [79:0] periph_req = '0, node_enable = '1, sw_req_set = '0, req_clr = '0;
    logic [319:0] node_prio = {80{4'h1}};
    logic [79:0] node_request_flag;
    logic [7:0] trap_flag_register;
    logic vector_ack, vector_valid, in_trap_service;
    logic [23:0] vector_addr;
    logic [6:0] vector_trap;
    logic [3:0] cur_prio;
    int failures = 0, n_compared = 0, cyc = 0;
    ivt_trap_entry uut (.sys_clk, .rst_b, .has_ser1, .vector_segment_select,
        .vector_spacing_field, .periph_req, .node_enable, .node_prio, .sw_req_set,
        .req_clr, .hw_trap_evt, .trap_flag_clr, .vector_ack, .service_done,
        .node_request_flag, .trap_flag_register, .vector_valid, .vector_addr,
        .vector_trap, .in_trap_service, .cur_prio);
    ivt_core_model core (.sys_clk, .vector_valid, .lag, .vector_ack);
    initial forever #50 sys_clk = ~sys_clk;
    task chk(string what, logic [23:0] exp, logic [23:0] got);
        n_compared++;
        if (exp !== got) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task vec(logic [6:0] tn);
        int i;
        i = 0;
        while (vector_valid !== 1'b1 && i < 20) begin
            @(negedge sys_clk);
            i++;
        end
        chk("vector_trap", 24'(tn), 24'(vector_trap));
        chk("vector_addr", {vector_segment_select,
            (16'(tn) << 2) << vector_spacing_field}, vector_addr);
        while (vector_valid !== 1'b0 && i < 40) begin
            @(negedge sys_clk);
            i++;
        end
    endtask : vec
    task quiet(int n);
        repeat (n) begin
            @(negedge sys_clk);
            chk("vector_valid", 24'h0, 24'(vector_valid));
        end
    endtask : quiet
    task done;
        service_done = 1'b1;
        @(negedge sys_clk) service_done = 1'b0;
        @(negedge sys_clk);
    endtask : done
    task pulse_req(int n);
        periph_req[n] = 1'b1;
        @(negedge sys_clk) periph_req = '0;
    endtask : pulse_req
    task t_trap;
        vector_segment_select = 8'h5a;
        hw_trap_evt = 8'h01;
        @(negedge sys_clk) hw_trap_evt = 8'h00;
        vec(7'h02);
        chk("in_trap_service", 24'h1, 24'(in_trap_service));
        chk("trap_flag_register", 24'h1, 24'(trap_flag_register));
        sw_req_set[16] = 1'b1;
        hw_trap_evt = 8'h02;
        @(negedge sys_clk) hw_trap_evt = 8'h00;
        sw_req_set = '0;
        quiet(5);
        chk("node_request_flag", 24'h1, 24'(node_request_flag[16]));
        done;
        vec(7'h04);
        chk("trap_flag_register", 24'h3, 24'(trap_flag_register));
        hw_trap_evt = 8'h01;
        @(negedge sys_clk) hw_trap_evt = 8'h00;
        vec(7'h02);
        trap_flag_clr = 8'h03;
        @(negedge sys_clk) trap_flag_clr = 8'h00;
        @(negedge sys_clk) chk("trap_flag_clr", 24'h0, 24'(trap_flag_register));
        done;
        vec(7'h20);
        done;
    endtask : t_trap
    task t_node;
        lag = 2'h2;
        for (int sp = 0; sp < 4; sp++) begin
            vector_spacing_field = 2'(sp);
            pulse_req(16);
            vec(7'h20);
            done;
        end
        vector_spacing_field = 2'h0;
        node_prio[20 +: 8] = 8'h55;
        node_prio[28 +: 4] = 4'h6;
        pulse_req(5);
        vec(7'h15);
        chk("cur_prio", 24'h5, 24'(cur_prio));
        pulse_req(6);
        quiet(4);
        pulse_req(7);
        vec(7'h17);
        hw_trap_evt = 8'h01;
        @(negedge sys_clk) hw_trap_evt = 8'h00;
        vec(7'h02);
        done;
        vec(7'h16);
        done;
        trap_flag_clr = 8'h01;
        @(negedge sys_clk) trap_flag_clr = 8'h00;
    endtask : t_node
    task t_free;
        has_ser1 = 1'b0;
        periph_req = 80'h4100_0f07_8000_0000_0000;
        @(negedge sys_clk) periph_req = '0;
        quiet(5);
        chk("free_flags", 24'h0, 24'(node_request_flag[63:47] & 17'h1e0f));
        chk("free_flags_hi", 24'h0, 24'(node_request_flag[79:64] & 16'h4100));
        sw_req_set[48] = 1'b1;
        @(negedge sys_clk) sw_req_set = '0;
        vec(7'h40);
        done;
        has_ser1 = 1'b1;
        pulse_req(56);
        vec(7'h48);
        done;
        pulse_req(79);
        vec(7'h5f);
        done;
        node_enable[9] = 1'b0;
        pulse_req(9);
        quiet(3);
        node_enable[9] = 1'b1;
        vec(7'h19);
        done;
        node_enable[9] = 1'b0;
        pulse_req(9);
        req_clr[9] = 1'b1;
        @(negedge sys_clk) req_clr = '0;
        chk("req_clr", 24'h0, 24'(node_request_flag[9]));
        node_enable[9] = 1'b1;
        quiet(3);
    endtask : t_free
    task finish_test;
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            finish_test;
        end
    end
    initial begin
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_trap;
        t_node;
        t_free;
        finish_test;
    end
endmodule : tb
